// *** design/cabi_bus.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cabi_regs.svh"

// How it works
// - Drive 23-bit word address for all cycles except interrupt acknowledge.
// - Interrupt acknowledge puts level on low three lines, upper lines high.
// - Sixteen-bit bidirectional data path carries words or single bytes.
// - Address valid strobe asserted only while a valid address is driven.
// - Direction high for read, low for write.
// - Upper strobe marks bits 8-15, lower marks bits 0-7.
// - Byte write copies the byte onto the unused lane too.
// - Read ends when acknowledge is seen, data latched then.
// - Write ends when acknowledge is seen.
// - Grant output says bus released at end of current cycle.
// - While mastership taken is asserted the bus belongs to another master.
// - Byte access: select bit zero uses upper strobe, one uses lower.
// - Cycle type all ones marks interrupt acknowledge, valid with strobe.

module cabi_bus (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Core request side
    input wire logic req_valid,
    input wire cabi_pkg::cabi_req_t req,
    output logic req_ready,
    output logic done,
    output logic [15:0] rdata,
    // Address and cycle type pins
    output logic [22:0] addr_out,
    output logic addr_oe,
    output logic [2:0] cycle_type_code,
    // Data pins
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    // Strobes and direction
    output cabi_pkg::cabi_strb_t strb,
    output logic strb_oe,
    input wire logic transfer_ack_n,
    // Arbitration
    input wire logic mastership_request_n,
    output logic mastership_grant_n,
    input wire logic mastership_taken_n
);
    cabi_pkg::cabi_state_t state_r, state_nxt;
    cabi_pkg::cabi_req_t cur_r;
    logic grant_r;

    wire upper_sel;
    wire lower_sel;
    wire [15:0] wdata_bus;

    cabi_lane cabi_lane_inst (
        .req(cur_r),
        .upper_sel(upper_sel),
        .lower_sel(lower_sel),
        .wdata_bus(wdata_bus)
    );

    wire ack = !transfer_ack_n;
    wire other_owns = !mastership_taken_n;
    wire bus_req = !mastership_request_n;
    wire in_idle = (state_r == cabi_pkg::CABI_IDLE);
    // A pending request blocks a new cycle once grant is out
    // no cycle when taken
    wire can_start = in_idle && req_valid && !grant_r && !other_owns;
    wire is_iack = (req.cycle_type == `CABI_FC_IACK);
    wire [22:0] start_addr = is_iack ? {`CABI_IACK_UPPER, req.irq_level} : req.word_addr;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            cabi_pkg::CABI_IDLE: begin
                if (other_owns) begin
                    state_nxt = cabi_pkg::CABI_OFF;
                end else if (can_start) begin
                    state_nxt = cabi_pkg::CABI_WAIT;
                end
            end
            cabi_pkg::CABI_WAIT: begin
                if (ack) begin
                    state_nxt = cabi_pkg::CABI_END;
                end
            end
            // Strobes negated; wait ack release so slave sees the end
            cabi_pkg::CABI_END: begin
                if (!ack) begin
                    state_nxt = other_owns ? cabi_pkg::CABI_OFF : cabi_pkg::CABI_IDLE;
                end
            end
            cabi_pkg::CABI_OFF: begin
                if (!other_owns) begin
                    state_nxt = cabi_pkg::CABI_IDLE;
                end
            end
            default: begin
                state_nxt = cabi_pkg::CABI_IDLE;
            end
        endcase
    end

    wire to_wait = (state_nxt == cabi_pkg::CABI_WAIT);
    wire ending = (state_r == cabi_pkg::CABI_WAIT) && ack;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= cabi_pkg::CABI_IDLE;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_r <= '0;
            addr_out <= 23'h00_0000;
            cycle_type_code <= 3'h0;
        end else if (clk_en && can_start) begin
            cur_r <= req;
            addr_out <= start_addr;
            cycle_type_code <= req.cycle_type;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            grant_r <= 1'b0;
            mastership_grant_n <= 1'b1;
        end else if (clk_en) begin
            grant_r <= bus_req && !other_owns;
            mastership_grant_n <= !(bus_req && !other_owns);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strb <= 4'b1111;
            strb_oe <= 1'b0;
            addr_oe <= 1'b0;
        end else if (clk_en) begin
            strb.addr_valid_strobe_n <= !to_wait;
            strb.upper_byte_strobe_n <= !(to_wait && (can_start ? (!req.byte_access
                || !req.internal_byte_select_bit) : upper_sel));
            strb.lower_byte_strobe_n <= !(to_wait && (can_start ? (!req.byte_access
                || req.internal_byte_select_bit) : lower_sel));
            strb.read_not_write <= can_start ? req.read : (to_wait ? cur_r.read : 1'b1);
            strb_oe <= (state_nxt != cabi_pkg::CABI_OFF);
            addr_oe <= to_wait;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            data_out <= 16'h0000;
            data_oe <= 1'b0;
        end else if (clk_en) begin
            data_out <= can_start ? (req.byte_access ? {req.wdata[7:0], req.wdata[7:0]}
                : req.wdata) : wdata_bus;
            data_oe <= to_wait && (can_start ? !req.read : !cur_r.read);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 16'h0000;
            done <= 1'b0;
            req_ready <= 1'b0;
        end else if (clk_en) begin
            done <= ending;
            req_ready <= can_start;
            if (ending && cur_r.read) begin
                rdata <= (cur_r.cycle_type == `CABI_FC_IACK) ? {8'h00, data_in[7:0]} : data_in;
            end
        end
    end
endmodule

`default_nettype wire

// *** pkg/cabi_regs.svh ***
`ifndef CABI_REGS_SVH
`define CABI_REGS_SVH

`define CABI_ADDR_W 23
`define CABI_DATA_W 16
`define CABI_LVL_W 3
`define CABI_FC_W 3
`define CABI_FC_IACK 3'h7
`define CABI_IACK_UPPER 20'hf_ffff
`define CABI_LANE_HI_LSB 8
`define CABI_LANE_LO_LSB 0

`endif

// *** pkg/cabi_pkg.sv ***
package cabi_pkg;

    typedef enum logic [3:0] {
        CABI_IDLE = 4'b0001,
        CABI_WAIT = 4'b0010,
        CABI_END = 4'b0100,
        CABI_OFF = 4'b1000
    } cabi_state_t;

    // One request from the processor core
    typedef struct packed {
        logic [22:0] word_addr;
        logic [15:0] wdata;
        logic [2:0] cycle_type;
        logic [2:0] irq_level;
        logic read;
        logic byte_access;
        logic internal_byte_select_bit;
    } cabi_req_t;

    // Strobe and direction outputs
    typedef struct packed {
        logic addr_valid_strobe_n;
        logic upper_byte_strobe_n;
        logic lower_byte_strobe_n;
        logic read_not_write;
    } cabi_strb_t;

endpackage

// *** design/cabi_lane.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "cabi_regs.svh"

// Byte lane steering: strobes and write data placement
module cabi_lane (
    // Request
    input wire cabi_pkg::cabi_req_t req,
    // Steering
    output logic upper_sel,
    output logic lower_sel,
    output logic [15:0] wdata_bus
);
    wire [7:0] wbyte = req.wdata[7:0];

    assign upper_sel = !req.byte_access || !req.internal_byte_select_bit;
    assign lower_sel = !req.byte_access || req.internal_byte_select_bit;

    assign wdata_bus = req.byte_access ? {wbyte, wbyte} : req.wdata;
endmodule

`default_nettype wire

// *** sim/cabi_monitor_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// Bus checker
module cabi_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Observed pins
    input wire logic done,
    input wire logic [22:0] addr_out,
    input wire logic addr_oe,
    input wire logic [2:0] cycle_type_code,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    input wire cabi_pkg::cabi_strb_t strb,
    input wire logic strb_oe,
    input wire logic transfer_ack_n,
    input wire logic mastership_request_n,
    input wire logic mastership_grant_n,
    input wire logic mastership_taken_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    wire as_on = !strb.addr_valid_strobe_n;
    sequence s_ack;
        as_on && !transfer_ack_n;
    endsequence
    sequence s_wait;
        as_on && transfer_ack_n;
    endsequence
    a_iack_addr: assert property (as_on && cycle_type_code == 3'h7 |-> &addr_out[22:3])
        else $error("iack address");
    a_strobe_addr: assert property (as_on |-> addr_oe && strb_oe)
        else $error("strobe without address");
    a_write_dir: assert property (data_oe |-> !strb.read_not_write)
        else $error("write direction");
    a_wait_hold: assert property (s_wait |=> as_on && $stable(addr_out) && $stable(strb))
        else $error("wait state not held");
    a_ack_end: assert property (s_ack |=> done && !as_on)
        else $error("cycle not ended");
    a_byte_copy: assert property (data_oe && as_on && (strb.upper_byte_strobe_n !=
        strb.lower_byte_strobe_n) |-> data_out[15:8] == data_out[7:0])
        else $error("byte lane copy");
    a_taken_float: assert property (!mastership_taken_n [*2] |-> !(strb_oe | addr_oe | data_oe))
        else $error("pins driven while taken");
    a_grant_reply: assert property (!mastership_request_n && mastership_taken_n
        |-> ##[0:2] !mastership_grant_n)
        else $error("no grant");
endmodule
`default_nettype wire

// *** sim/cabi_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// Slave model
module cabi_slave (
    // Clock
    input wire logic clk,
    // Processor pins
    input wire cabi_pkg::cabi_strb_t strb,
    input wire logic [22:0] addr_out,
    input wire logic [15:0] data_out,
    input wire logic [3:0] delay,
    // Replies
    output logic transfer_ack_n,
    output logic [15:0] data_in,
    output logic [15:0] wr_data
);
    logic [3:0] cnt_r = 4'h0;
    initial transfer_ack_n = 1'b1;
    initial data_in = 16'h5a5a;
    always @(posedge clk) begin
        if (strb.addr_valid_strobe_n) begin
            cnt_r <= 4'h0;
            transfer_ack_n <= 1'b1;
            // Released bus inverts its data every cycle, so stale data shows again on alternate cycles
            data_in <= ~data_in;
        end else if (cnt_r != delay) begin
            cnt_r <= cnt_r + 4'h1;
        end else begin
            transfer_ack_n <= 1'b0;
            wr_data <= data_out;
            data_in <= {~addr_out[7:0], addr_out[7:0]};
        end
    end
endmodule
`default_nettype wire

// *** sim/test_cpu_async_bus_interface.sv ***
`timescale 1ns/100ps
`default_nettype none
// ====
// Bench top
module test_cpu_async_bus_interface;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic req_valid = 1'b0;
    logic mastership_request_n = 1'b1;
    logic mastership_taken_n = 1'b1;
    logic [3:0] delay = 4'h2;
    cabi_pkg::cabi_req_t req = '0;
    cabi_pkg::cabi_strb_t strb;
    logic req_ready, done, addr_oe, data_oe, strb_oe, mastership_grant_n, transfer_ack_n;
    logic [15:0] rdata, data_in, data_out, wr_data;
    logic [22:0] addr_out;
    logic [2:0] cycle_type_code;
    int miscompares = 0;
    int checked = 0;
    initial forever #5 clk = ~clk;
    cabi_bus cabi_bus_inst (.clk, .nrst, .clk_en(1'b1), .req_valid, .req, .req_ready, .done,
        .rdata, .addr_out, .addr_oe, .cycle_type_code, .data_in, .data_out, .data_oe, .strb,
        .strb_oe, .transfer_ack_n, .mastership_request_n, .mastership_grant_n,
        .mastership_taken_n);
    cabi_slave cabi_slave_inst (.clk, .strb, .addr_out, .data_out, .delay, .transfer_ack_n,
        .data_in, .wr_data);
    task final_report;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [22:0] e, input logic [22:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task run(input cabi_pkg::cabi_req_t r, input logic [22:0] ea, input logic [2:0] es);
        @(negedge clk);
        req = r;
        req_valid = 1'b1;
        for (int n = 0; n < 40 && req_ready !== 1'b1; n++) @(negedge clk);
        req_valid = 1'b0;
        chk("addr", ea, addr_out);
        chk("strobes", es, strb[2:0]);
        chk("code", r.cycle_type, cycle_type_code);
        for (int n = 0; n < 40 && done !== 1'b1; n++) @(negedge clk);
        chk("done", 1, done);
    endtask
    task t_read;
        cabi_pkg::cabi_req_t r;
        r = '0;
        r.word_addr = 23'h12_3456;
        r.read = 1'b1;
        r.cycle_type = 3'h5;
        delay = 4'h3;
        run(r, r.word_addr, 3'h1);
        chk("rdata", {~r.word_addr[7:0], r.word_addr[7:0]}, rdata);
        $display("read test done");
    endtask
    task t_write;
        cabi_pkg::cabi_req_t r;
        r = '0;
        r.word_addr = 23'h40_0001;
        r.byte_access = 1'b1;
        r.wdata = 16'h00c3;
        r.cycle_type = 3'h1;
        for (int s = 0; s < 2; s++) begin
            r.internal_byte_select_bit = s[0];
            delay = s[0] ? 4'h5 : 4'h0;
            run(r, r.word_addr, {s[0], ~s[0], 1'b0});
            chk("copy", 16'hc3c3, wr_data);
        end
        $display("write test done");
    endtask
    task t_iack;
        cabi_pkg::cabi_req_t r;
        r = '0;
        r.read = 1'b1;
        r.cycle_type = 3'h7;
        r.irq_level = 3'h5;
        run(r, 23'h7f_fffd, 3'h1);
        chk("vector", 16'h00fd, rdata);
        $display("iack test done");
    endtask
    task t_arb;
        cabi_pkg::cabi_req_t r;
        r = '0;
        r.word_addr = 23'h0abc;
        r.read = 1'b1;
        @(negedge clk);
        mastership_request_n = 1'b0;
        repeat (3) @(negedge clk);
        chk("grant", 0, mastership_grant_n);
        while (!(strb.addr_valid_strobe_n && transfer_ack_n)) @(negedge clk);
        mastership_taken_n = 1'b0;
        mastership_request_n = 1'b1;
        req = r;
        req_valid = 1'b1;
        repeat (4) @(negedge clk);
        chk("held off", 0, req_ready | strb_oe | addr_oe);
        mastership_taken_n = 1'b1;
        req_valid = 1'b0;
        run(r, r.word_addr, 3'h1);
        $display("arbitration test done");
    endtask
    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        t_read;
        t_write;
        t_iack;
        t_arb;
        final_report;
    end
    initial begin
        #20000;
        miscompares++;
        final_report;
    end
endmodule
bind cabi_bus cabi_monitor cabi_monitor_inst (.clk, .nrst, .done, .addr_out, .addr_oe,
    .cycle_type_code, .data_out, .data_oe, .strb, .strb_oe, .transfer_ack_n,
    .mastership_request_n, .mastership_grant_n, .mastership_taken_n);
`default_nettype wire
